// [ttr_rx_main.v]
// Receive trail trace processor: bit assembly, alignment, identifier
// storage, comparison, status and register slave.
// Assumes trace bits arrive from framer logic on core_clk, at most one per
// cycle, with a byte-start marker on the first bit of every byte.
//
// What this block does
// - Align to multiframe while alignment enabled
// - Alignment disabled: store from arbitrary byte
// - Compare to expected only when enabled
// - Alignment disabled suppresses comparison
// - Invert incoming bits when inversion set
// - First bit to bit 7, or bit 0
// - Expected pointer in bits 11:8
// - Expected data access advances pointer, wraps
// - Received pointer in bits 3:0
// - Received data access advances pointer, wraps
// - Mismatch bit while received differs expected
// - Unstable after eight unmatched identifiers
// - Idle after five all-zero identifiers
// - Latch change flag on identifier update
`timescale 1ns/1ps
`default_nettype none
`include "ttr_defs.vh"

module ttr_rx_main (
    input  wire                    core_clk,
    input  wire                    nrst,
    input  wire                    rx_tt_bit,
    input  wire                    rx_tt_bit_vld,
    input  wire                    rx_tt_byte_start,
    input  wire [`TTR_ADDR_W-1:0]  reg_addr,
    input  wire [`TTR_DATA_W-1:0]  reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output wire [`TTR_DATA_W-1:0]  reg_rdata,
    output wire                    irq,
    output wire                    mismatch_condition,
    output wire                    unstable_condition
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function [7:0] shift_in;
        input [7:0] sh;
        input       b;
        input       reorder;
        begin
            if (reorder) begin
                shift_in = {b, sh[7:1]};
            end else begin
                shift_in = {sh[6:0], b};
            end
        end
    endfunction

    function [3:0] ptr_next;
        input [3:0] p;
        begin
            ptr_next = p + 4'h1;
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [3:0]  ctrl_q;
    reg  [3:0]  expected_byte_pointer_q;
    reg  [3:0]  received_byte_pointer_q;
    reg  [3:0]  latch_q;
    reg  [3:0]  irq_en_q;
    reg  [15:0] rd_reg_q;
    reg  [1:0]  rd_sel_q;

    wire        rx_align_disable      = ctrl_q[`TTR_CTRL_ALIGN_DIS];
    wire        rx_compare_enable     = ctrl_q[`TTR_CTRL_CMP_EN];
    wire        rx_invert_enable      = ctrl_q[`TTR_CTRL_INVERT];
    wire        rx_bit_reorder_enable = ctrl_q[`TTR_CTRL_REORDER];

    wire        cmp_active = rx_compare_enable & ~rx_align_disable;

    wire        hit_recv = (reg_addr == `TTR_OFS_RECV);
    wire        hit_exp  = (reg_addr == `TTR_OFS_EXP);
    wire        wr_ctrl  = reg_wr & (reg_addr == `TTR_OFS_CTRL);
    wire        wr_ptr   = reg_wr & (reg_addr == `TTR_OFS_PTR);
    wire        wr_latch = reg_wr & (reg_addr == `TTR_OFS_LATCH);
    wire        wr_irqen = reg_wr & (reg_addr == `TTR_OFS_IRQ_EN);
    wire        acc_recv = (reg_wr | reg_rd) & hit_recv;
    wire        acc_exp  = (reg_wr | reg_rd) & hit_exp;

    // ----------------------------------------------------------------
    // Bit assembly
    // ----------------------------------------------------------------
    reg  [7:0]  sh_q;
    reg  [2:0]  bit_cnt_q;
    reg         in_byte_q;
    reg         first_bit_q;
    reg  [3:0]  pos_q;
    reg         byte_vld_q;
    reg  [7:0]  byte_q;
    reg  [3:0]  byte_pos_q;

    wire        line_bit = rx_tt_bit ^ rx_invert_enable;
    wire [7:0]  sh_d     = shift_in(sh_q, line_bit, rx_bit_reorder_enable);
    wire        byte_done = rx_tt_bit_vld & ~rx_tt_byte_start & in_byte_q &
                            (bit_cnt_q == `TTR_LAST_BIT);
    // The first bit carries the multiframe marker; set only on byte 0
    wire        mas_seen = ~rx_align_disable & first_bit_q;
    wire [3:0]  pos_d    = mas_seen ? 4'h0 : ptr_next(pos_q);

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sh_q        <= 8'h00;
            bit_cnt_q   <= 3'h0;
            in_byte_q   <= 1'b0;
            first_bit_q <= 1'b0;
            pos_q       <= 4'h0;
            byte_vld_q  <= 1'b0;
            byte_q      <= 8'h00;
            byte_pos_q  <= 4'h0;
        end else begin
            byte_vld_q <= byte_done;
            if (rx_tt_bit_vld) begin
                sh_q <= sh_d;
                if (rx_tt_byte_start) begin
                    in_byte_q   <= 1'b1;
                    bit_cnt_q   <= 3'h1;
                    first_bit_q <= line_bit;
                end else if (in_byte_q) begin
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                end
            end
            if (byte_done) begin
                in_byte_q  <= 1'b0;
                byte_q     <= sh_d;
                pos_q      <= pos_d;
                byte_pos_q <= pos_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Compare stage: old stored byte and expected byte come back here
    // ----------------------------------------------------------------
    reg         cmp_vld_q;
    reg  [7:0]  cmp_byte_q;
    reg  [3:0]  cmp_pos_q;
    reg         acc_exp_q;
    reg         acc_cur_q;
    reg         acc_nz_q;
    wire [7:0]  recv_b_rdata;
    wire [7:0]  exp_b_rdata;
    wire [7:0]  recv_a_rdata;
    wire [7:0]  exp_a_rdata;

    // Port B sees a read in one cycle and a write in the next; bytes are at
    // least eight strobes apart, so the two never collide
    wire [3:0]  b_addr  = cmp_vld_q ? cmp_pos_q : byte_pos_q;
    wire        first   = (cmp_pos_q == 4'h0);
    wire        d_exp   = (first ? 1'b0 : acc_exp_q) | (cmp_byte_q != exp_b_rdata);
    wire        d_cur   = (first ? 1'b0 : acc_cur_q) | (cmp_byte_q != recv_b_rdata);
    wire        d_nz    = (first ? 1'b0 : acc_nz_q) | (cmp_byte_q != 8'h00);
    wire        id_end  = cmp_vld_q & (cmp_pos_q == `TTR_ID_LAST_POS);

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmp_vld_q  <= 1'b0;
            cmp_byte_q <= 8'h00;
            cmp_pos_q  <= 4'h0;
            acc_exp_q  <= 1'b0;
            acc_cur_q  <= 1'b0;
            acc_nz_q   <= 1'b0;
        end else begin
            cmp_vld_q <= byte_vld_q;
            if (byte_vld_q) begin
                cmp_byte_q <= byte_q;
                cmp_pos_q  <= byte_pos_q;
            end
            if (cmp_vld_q) begin
                acc_exp_q <= d_exp;
                acc_cur_q <= d_cur;
                acc_nz_q  <= d_nz;
            end
        end
    end

    // ----------------------------------------------------------------
    // Identifier conditions, judged once per whole identifier
    // ----------------------------------------------------------------
    reg         mism_q;
    reg  [3:0]  unst_cnt_q;
    reg  [2:0]  idle_cnt_q;
    reg  [2:0]  live_prev_q;

    wire        id_mismatch_status = mism_q;
    wire        id_unstable_status = (unst_cnt_q == `TTR_UNSTABLE_COUNT);
    wire        id_idle_status     = (idle_cnt_q == `TTR_IDLE_COUNT);
    wire [2:0]  live = {id_mismatch_status, id_unstable_status, id_idle_status};
    // With comparison off nothing can match the expected identifier
    wire        no_match = (~cmp_active | d_exp) & d_cur;
    wire        id_change_latched_evt = id_end & d_cur;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mism_q      <= 1'b0;
            unst_cnt_q  <= 4'h0;
            idle_cnt_q  <= 3'h0;
            live_prev_q <= 3'h0;
        end else begin
            live_prev_q <= live;
            if (!cmp_active) begin
                mism_q <= 1'b0;
            end else if (id_end) begin
                mism_q <= d_exp;
            end
            if (id_end) begin
                if (!no_match) begin
                    unst_cnt_q <= 4'h0;
                end else if (!id_unstable_status) begin
                    unst_cnt_q <= unst_cnt_q + 4'h1;
                end
                if (d_nz) begin
                    idle_cnt_q <= 3'h0;
                end else if (!id_idle_status) begin
                    idle_cnt_q <= idle_cnt_q + 3'h1;
                end
            end
        end
    end

    assign mismatch_condition = id_mismatch_status;
    assign unstable_condition = id_unstable_status;

    // ----------------------------------------------------------------
    // Identifier stores
    // ----------------------------------------------------------------
    ttr_id_mem #(
        .DW (8),
        .AW (4)
    ) u_recv_mem (
        .core_clk (core_clk),
        .a_we     (1'b0),
        .a_addr   (received_byte_pointer_q),
        .a_wdata  (8'h00),
        .a_rdata  (recv_a_rdata),
        .b_we     (cmp_vld_q),
        .b_addr   (b_addr),
        .b_wdata  (cmp_byte_q),
        .b_rdata  (recv_b_rdata)
    );

    ttr_id_mem #(
        .DW (8),
        .AW (4)
    ) u_exp_mem (
        .core_clk (core_clk),
        .a_we     (reg_wr & hit_exp),
        .a_addr   (expected_byte_pointer_q),
        .a_wdata  (reg_wdata[7:0]),
        .a_rdata  (exp_a_rdata),
        .b_we     (1'b0),
        .b_addr   (b_addr),
        .b_wdata  (8'h00),
        .b_rdata  (exp_b_rdata)
    );

    // ----------------------------------------------------------------
    // Register writes, pointers and latched status
    // ----------------------------------------------------------------
    wire [3:0]  latch_set = {id_change_latched_evt, live & ~live_prev_q};

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q                  <= `TTR_CTRL_RESET;
            expected_byte_pointer_q <= `TTR_PTR_RESET;
            received_byte_pointer_q <= `TTR_PTR_RESET;
            latch_q                 <= 4'h0;
            irq_en_q                <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[3:0];
            end
            if (wr_ptr) begin
                expected_byte_pointer_q <= reg_wdata[`TTR_PTR_EXP_LSB+3:`TTR_PTR_EXP_LSB];
                received_byte_pointer_q <= reg_wdata[`TTR_PTR_RECV_LSB+3:`TTR_PTR_RECV_LSB];
            end
            if (acc_exp) begin
                expected_byte_pointer_q <= ptr_next(expected_byte_pointer_q);
            end
            if (acc_recv) begin
                received_byte_pointer_q <= ptr_next(received_byte_pointer_q);
            end
            if (wr_irqen) begin
                irq_en_q <= reg_wdata[3:0];
            end
            // A new event in the clearing cycle survives the clear
            latch_q <= (latch_q & ~(wr_latch ? reg_wdata[3:0] : 4'h0)) | latch_set;
        end
    end

    assign irq = |(latch_q & irq_en_q);

    // ----------------------------------------------------------------
    // Register reads: value stands in the cycle after the strobe
    // ----------------------------------------------------------------
    reg  [15:0] rd_mux;

    always @* begin
        rd_mux = 16'h0000;
        case (reg_addr)
            `TTR_OFS_CTRL: begin
                rd_mux = {12'h000, ctrl_q};
            end
            `TTR_OFS_PTR: begin
                rd_mux = {4'h0, expected_byte_pointer_q, 4'h0, received_byte_pointer_q};
            end
            `TTR_OFS_LIVE: begin
                rd_mux = {13'h0000, live};
            end
            `TTR_OFS_LATCH: begin
                rd_mux = {12'h000, latch_q};
            end
            `TTR_OFS_IRQ_EN: begin
                rd_mux = {12'h000, irq_en_q};
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_reg_q <= 16'h0000;
            rd_sel_q <= 2'h0;
        end else if (reg_rd) begin
            rd_reg_q <= rd_mux;
            rd_sel_q <= hit_recv ? 2'h1 : (hit_exp ? 2'h2 : 2'h0);
        end
    end

    // Memory bytes come from the store's own read register
    assign reg_rdata = (rd_sel_q == 2'h1) ? {8'h00, recv_a_rdata} :
                       (rd_sel_q == 2'h2) ? {8'h00, exp_a_rdata} : rd_reg_q;

endmodule

`default_nettype wire

// [ttr_defs.vh]
// Register map, field positions and counts of the trail trace receiver.
// Included by the receiver top, the checker and the bench, not by the identifier store; definitions only.
`ifndef TTR_DEFS_VH
`define TTR_DEFS_VH

`define TTR_ADDR_W          8
`define TTR_DATA_W          16

`define TTR_OFS_CTRL        8'hF0
`define TTR_OFS_PTR         8'hF2
`define TTR_OFS_LIVE        8'hF4
`define TTR_OFS_LATCH       8'hF6
`define TTR_OFS_IRQ_EN      8'hF8
`define TTR_OFS_RECV        8'hFC
`define TTR_OFS_EXP         8'hFE

`define TTR_CTRL_ALIGN_DIS  3
`define TTR_CTRL_CMP_EN     2
`define TTR_CTRL_INVERT     1
`define TTR_CTRL_REORDER    0
`define TTR_CTRL_RESET      4'h0

`define TTR_PTR_EXP_LSB     8
`define TTR_PTR_RECV_LSB    0
`define TTR_PTR_RESET       4'h0

`define TTR_ST_MISMATCH     2
`define TTR_ST_UNSTABLE     1
`define TTR_ST_IDLE         0
`define TTR_ST_CHANGE       3

`define TTR_ID_LAST_POS     4'hF
`define TTR_UNSTABLE_COUNT  4'h8
`define TTR_IDLE_COUNT      3'h5
`define TTR_LAST_BIT        3'h7

`endif

// [ttr_id_mem.v]
// Sixteen-byte identifier store with two ports, both reading into registers.
// Assumes the two ports never write the same byte in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module ttr_id_mem #(
    parameter DW = 8,
    parameter AW = 4
) (
    input  wire          core_clk,
    input  wire          a_we,
    input  wire [AW-1:0] a_addr,
    input  wire [DW-1:0] a_wdata,
    output reg  [DW-1:0] a_rdata,
    input  wire          b_we,
    input  wire [AW-1:0] b_addr,
    input  wire [DW-1:0] b_wdata,
    output reg  [DW-1:0] b_rdata
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read-before-write on each port: the old byte comes out
    always @(posedge core_clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end

endmodule

`default_nettype wire

// [ttr_rx_main_sva.sv]
// Checker of the trail trace receiver, watching only the top ports.
// Assumes the register and line timing given with the block.
`timescale 1ns/1ps
`default_nettype none
`include "ttr_defs.vh"

module ttr_rx_main_sva (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        rx_tt_bit,
    input wire logic        rx_tt_bit_vld,
    input wire logic        rx_tt_byte_start,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        irq,
    input wire logic        mismatch_condition,
    input wire logic        unstable_condition
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic [3:0]       ctrl_q;
    logic [1:0]       age_q;
    logic [4:0]       quiet_q;
    wire logic        w_ctrl = reg_wr && reg_addr == `TTR_OFS_CTRL;
    wire logic        w_ptr  = reg_wr && reg_addr == `TTR_OFS_PTR;
    wire logic        r_ptr  = reg_rd && reg_addr == `TTR_OFS_PTR;
    wire logic [3:0]  w_exp  = reg_wdata[11:8];
    wire logic [3:0]  w_rcv  = reg_wdata[3:0];
    wire logic [1:0]  cond   = {mismatch_condition, unstable_condition};

    // Age saturates so a control change is judged only once it settled
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q  <= 4'h0;
            age_q   <= 2'h3;
            quiet_q <= 5'h1F;
        end else begin
            if (w_ctrl) begin
                ctrl_q <= reg_wdata[3:0];
                age_q  <= 2'h0;
            end else if (age_q != 2'h3) begin
                age_q <= age_q + 2'h1;
            end
            if (rx_tt_bit_vld)
                quiet_q <= 5'h00;
            else if (quiet_q != 5'h1F)
                quiet_q <= quiet_q + 5'h01;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_live_rd;
        reg_rd && reg_addr == `TTR_OFS_LIVE |=> reg_rdata[15:3] == 13'h0
            && reg_rdata[2:1] == $past(cond);
    endproperty
    a_live_rd: assert property (p_live_rd)
        else $error("live status read wrong");

    property p_ptr_rb;
        w_ptr ##1 r_ptr |=> reg_rdata == ($past(reg_wdata, 2) & 16'h0F0F);
    endproperty
    a_ptr_rb: assert property (p_ptr_rb)
        else $error("pointer readback wrong");

    property p_exp_adv;
        w_ptr ##1 (reg_wr && reg_addr == `TTR_OFS_EXP) ##1 r_ptr |=>
            reg_rdata[11:8] == $past(w_exp, 3) + 4'h1 && reg_rdata[3:0] == $past(w_rcv, 3);
    endproperty
    a_exp_adv: assert property (p_exp_adv)
        else $error("expected pointer step wrong");

    property p_rcv_adv;
        w_ptr ##1 (reg_rd && reg_addr == `TTR_OFS_RECV) ##2 r_ptr |=>
            reg_rdata[3:0] == $past(w_rcv, 4) + 4'h1 && reg_rdata[11:8] == $past(w_exp, 4);
    endproperty
    a_rcv_adv: assert property (p_rcv_adv)
        else $error("received pointer step wrong");

    property p_ctrl_rb;
        w_ctrl ##1 (reg_rd && reg_addr == `TTR_OFS_CTRL) |=>
            reg_rdata == ($past(reg_wdata, 2) & 16'h000F);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control readback wrong");

    property p_cmp_off;
        age_q == 2'h3 && !ctrl_q[2] |-> !mismatch_condition;
    endproperty
    a_cmp_off: assert property (p_cmp_off)
        else $error("mismatch while compare off");

    property p_align_off;
        age_q == 2'h3 && ctrl_q[3] |-> !mismatch_condition;
    endproperty
    a_align_off: assert property (p_align_off)
        else $error("mismatch while alignment off");

    property p_mis_judge;
        $rose(mismatch_condition) |-> quiet_q < 5'h08;
    endproperty
    a_mis_judge: assert property (p_mis_judge)
        else $error("mismatch rose away from a judgement");

    property p_unst_judge;
        $changed(unstable_condition) |-> quiet_q < 5'h08;
    endproperty
    a_unst_judge: assert property (p_unst_judge)
        else $error("unstable moved away from a judgement");

    property p_irq_mask;
        reg_wr && reg_addr == `TTR_OFS_IRQ_EN && reg_wdata[3:0] == 4'h0 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt while all masked");

    c_idle: cover property (reg_rd && reg_addr == `TTR_OFS_LIVE ##1 reg_rdata[0]);
    c_mis: cover property ($rose(mismatch_condition));
    c_irq: cover property ($rose(irq));
endmodule

bind ttr_rx_main ttr_rx_main_sva i_sva (
    .core_clk, .nrst, .rx_tt_bit, .rx_tt_bit_vld, .rx_tt_byte_start, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .mismatch_condition,
    .unstable_condition
);
`default_nettype wire

// [ttr_far_tx.sv]
// Far-end transmitter: sends a 16-byte identifier, byte 0 first, each
// byte most significant bit first, optional idle cycles between bits.
// Assumes send is pulsed for one cycle while busy is low.
`timescale 1ns/1ps
`default_nettype none

module ttr_far_tx (
    input  wire logic         core_clk,
    input  wire logic         send,
    input  wire logic [127:0] id,
    input  wire logic [1:0]   gap,
    output var  logic         busy,
    output var  logic         rx_tt_bit,
    output var  logic         rx_tt_bit_vld,
    output var  logic         rx_tt_byte_start
);
    int i;

    initial begin
        busy = 1'b0;
        rx_tt_bit = 1'b0;
        rx_tt_bit_vld = 1'b0;
        rx_tt_byte_start = 1'b0;
        forever begin
            @(posedge core_clk);
            if (send) begin
                busy <= 1'b1;
                for (i = 0; i < 128; i++) begin
                    rx_tt_bit        <= id[8 * (i / 8) + 7 - i % 8];
                    rx_tt_bit_vld    <= 1'b1;
                    rx_tt_byte_start <= (i % 8 == 0);
                    @(posedge core_clk);
                    // Line toggles when idle so a stale bit is never mistaken for data
                    if (gap != 2'h0) begin
                        rx_tt_bit_vld    <= 1'b0;
                        rx_tt_byte_start <= 1'b0;
                        rx_tt_bit        <= ~rx_tt_bit;
                        repeat (gap) @(posedge core_clk);
                    end
                end
                busy             <= 1'b0;
                rx_tt_bit_vld    <= 1'b0;
                rx_tt_byte_start <= 1'b0;
                rx_tt_bit        <= ~rx_tt_bit;
            end
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the trail trace receiver with a far-end model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "ttr_defs.vh"

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top;
    logic         core_clk;
    logic         nrst;
    logic [7:0]   reg_addr;
    logic [15:0]  reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [15:0]  reg_rdata;
    logic         irq;
    logic         mismatch_condition;
    logic         unstable_condition;
    logic         rx_tt_bit;
    logic         rx_tt_bit_vld;
    logic         rx_tt_byte_start;
    logic         send;
    logic [1:0]   gap;
    logic         busy;
    logic [127:0] tx_id;
    logic [127:0] id_a;
    logic [127:0] id_b;
    int           n_fail;
    int           n_checks;
    int           k;

    ttr_rx_main i_ttr_rx_main (
        .core_clk, .nrst, .rx_tt_bit, .rx_tt_bit_vld, .rx_tt_byte_start, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .mismatch_condition,
        .unstable_condition
    );
    ttr_far_tx i_ttr_far_tx (
        .core_clk, .send, .id(tx_id), .gap, .busy, .rx_tt_bit, .rx_tt_bit_vld,
        .rx_tt_byte_start
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Write strobe stays up until the next task lowers it
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
        reg_addr <= a;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // Mid-cycle sample stays clear of the edge that reloads the store read register
        @(negedge core_clk);
        `CHK(nm, e, reg_rdata)
        @(posedge core_clk);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic send_id(input logic [127:0] v, input logic [1:0] g);
        reg_wr <= 1'b0;
        tx_id  <= v;
        gap    <= g;
        send   <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        @(posedge core_clk);
        for (k = 0; k < 600 && busy === 1'b1; k++) @(posedge core_clk);
        if (busy !== 1'b0) n_fail++;
        repeat (8) @(posedge core_clk);
    endtask
    // Byte 0 alone carries a one in both end bits, so either bit order aligns
    function automatic logic [127:0] mk(input logic [7:0] b5);
        logic [127:0] r;
        for (int j = 0; j < 16; j++) r[8 * j +: 8] = 8'(j * 4);
        r[7:0]   = 8'h81;
        r[47:40] = b5;
        return r;
    endfunction
    function automatic logic [127:0] xf(input logic [127:0] v, input bit inv, input bit rev);
        logic [127:0] r;
        for (int j = 0; j < 128; j++) r[j] = v[rev ? 8 * (j / 8) + 7 - j % 8 : j] ^ inv;
        return r;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        n_fail = 0;
        n_checks = 0;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        send = 1'b0;
        gap = 2'h0;
        tx_id = 128'h0;
        id_a = mk(8'h14);
        id_b = mk(8'h7E);
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd_chk(`TTR_OFS_CTRL, 16'h0000, "ctrl_rst");
        rd_chk(`TTR_OFS_PTR, 16'h0000, "ptr_rst");
        rd_chk(`TTR_OFS_IRQ_EN, 16'h0000, "irq_en_rst");
        rd_chk(`TTR_OFS_LATCH, 16'h0000, "latch_rst");
        wr(`TTR_OFS_LIVE, 16'hFFFF);
        rd_chk(`TTR_OFS_LIVE, 16'h0000, "live_ro");
        wr(8'hFA, 16'hFFFF);
        rd_chk(8'hFA, 16'h0000, "unused");
        wr(`TTR_OFS_CTRL, 16'hFFFF);
        rd_chk(`TTR_OFS_CTRL, 16'h000F, "ctrl_rb");
        wr(`TTR_OFS_PTR, 16'hFFFF);
        rd_chk(`TTR_OFS_PTR, 16'h0F0F, "ptr_rb");
        wr(`TTR_OFS_PTR, 16'h0F0F);
        wr(`TTR_OFS_EXP, 16'h0055);
        rd_chk(`TTR_OFS_PTR, 16'h000F, "exp_wrap");
        wr(`TTR_OFS_PTR, 16'h0000);
        for (int j = 0; j < 16; j++) wr(`TTR_OFS_EXP, {8'h00, id_a[8 * j +: 8]});
        for (int j = 0; j < 16; j++) rd_chk(`TTR_OFS_EXP, {8'h00, id_a[8 * j +: 8]}, "exp");
        wr(`TTR_OFS_CTRL, 16'h0004);
        send_id(id_a, 2'h0);
        send_id(id_a, 2'h1);
        wr(`TTR_OFS_LATCH, 16'h000F);
        send_id(id_a, 2'h2);
        rd_chk(`TTR_OFS_LATCH, 16'h0000, "no_change");
        `CHK("mis_a", 1'b0, mismatch_condition)
        wr(`TTR_OFS_PTR, 16'h0000);
        for (int j = 0; j < 16; j++) rd_chk(`TTR_OFS_RECV, {8'h00, id_a[8 * j +: 8]}, "rcv");
        wr(`TTR_OFS_PTR, 16'h000F);
        rd_chk(`TTR_OFS_RECV, {8'h00, id_a[127:120]}, "rcv_last");
        rd_chk(`TTR_OFS_PTR, 16'h0000, "rcv_wrap");
        send_id(id_b, 2'h0);
        `CHK("mis_b", 1'b1, mismatch_condition)
        rd_chk(`TTR_OFS_LATCH, 16'h000C, "latch_b");
        `CHK("irq_masked", 1'b0, irq)
        wr(`TTR_OFS_IRQ_EN, 16'h0004);
        idle(1);
        `CHK("irq_on", 1'b1, irq)
        wr(`TTR_OFS_LATCH, 16'h0004);
        idle(1);
        `CHK("irq_clr", 1'b0, irq)
        wr(`TTR_OFS_IRQ_EN, 16'h0008);
        idle(1);
        `CHK("irq_change", 1'b1, irq)
        wr(`TTR_OFS_IRQ_EN, 16'h0000);
        send_id({id_a[23:0], id_a[127:24]}, 2'h0);
        send_id({id_a[23:0], id_a[127:24]}, 2'h0);
        `CHK("mis_align", 1'b0, mismatch_condition)
        send_id(id_b, 2'h0);
        wr(`TTR_OFS_CTRL, 16'h000C);
        idle(3);
        `CHK("mis_suppr", 1'b0, mismatch_condition)
        wr(`TTR_OFS_CTRL, 16'h0006);
        send_id(xf(id_a, 1'b1, 1'b0), 2'h1);
        `CHK("mis_inv", 1'b0, mismatch_condition)
        wr(`TTR_OFS_CTRL, 16'h0005);
        send_id(xf(id_a, 1'b0, 1'b1), 2'h0);
        `CHK("mis_rev", 1'b0, mismatch_condition)
        wr(`TTR_OFS_CTRL, 16'h000C);
        for (int n = 0; n < 5; n++) begin
            send_id(128'h0, 2'h0);
            if (n == 3)
                rd_chk(`TTR_OFS_LIVE, 16'h0000, "idle4");
        end
        rd_chk(`TTR_OFS_LIVE, 16'h0001, "idle5");
        for (int n = 0; n < 8; n++) begin
            send_id(mk(8'h40 + 8'(n)), 2'h0);
            if (n == 6)
                `CHK("unst7", 1'b0, unstable_condition)
        end
        rd_chk(`TTR_OFS_LIVE, 16'h0002, "unst8");
        send_id({id_a[23:0], id_a[127:24]}, 2'h0);
        wr(`TTR_OFS_PTR, 16'h0000);
        rd_chk(`TTR_OFS_RECV, 16'h000C, "rcv_noalign");
        tally_and_finish();
    end
endmodule
`default_nettype wire
